// ### verilog/line_state_pkg.sv
// Constants, states and index names for the full-speed line-state detector.
// Assumes a 100 MHz CLK and receiver comparator outputs from the pad ring.
// Function
// - Bit timing derived from 12 Mb/s rate
// - Differential one: positive difference, D+ driven high
// - Differential zero: negative difference, D- driven high
// - SE0 when both lines below driven threshold
// - Full-speed idle: D+ floating high, D- low
// - Low-speed idle: mirror of full-speed idle
// - Start of packet on idle-to-K transition
// - End of packet: SE0 then J
// - SE0 width measured with approximate bit boundary
// - Bus reset after lines low 2.5 us
package line_state_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PS = 10000;
    localparam int BIT_RATE_BPS = 12000000;
    localparam int BIT_PS = 1000000000 / (BIT_RATE_BPS / 1000);
    localparam int HOST_RESET_MS = 10;
    localparam int RESET_DET_NS_X10 = 25;
    localparam int RESET_DET_PS = RESET_DET_NS_X10 * 100000;
    localparam int BIT_TOL_NUM = 3;
    localparam int BIT_TOL_DEN = 4;
    localparam int EOP_MIN_PS = BIT_PS * BIT_TOL_NUM / BIT_TOL_DEN;
    localparam int EOP_MIN_CYC = (EOP_MIN_PS + CLK_PS - 1) / CLK_PS;
    localparam int RESET_CYC = (RESET_DET_PS + CLK_PS - 1) / CLK_PS;
    localparam int CNT_W = 10;
    typedef logic [CNT_W-1:0] count_t;
    localparam count_t CNT_ZERO = 10'h000;
    localparam count_t CNT_ONE = 10'h001;
    localparam count_t EOP_MIN = count_t'(EOP_MIN_CYC);
    localparam count_t RESET_MIN = count_t'(RESET_CYC);

    // ---------------------------------------------------------------
    // Receiver comparator bits
    // ---------------------------------------------------------------
    localparam int SENSE_W = 8;
    typedef logic [SENSE_W-1:0] sense_t;
    localparam sense_t SENSE_RST = 8'h00;
    localparam int S_DIFF_POS = 0;
    localparam int S_DIFF_NEG = 1;
    localparam int S_DP_DRIVEN = 2;
    localparam int S_DM_DRIVEN = 3;
    localparam int S_DP_FLOAT = 4;
    localparam int S_DM_FLOAT = 5;
    localparam int S_DP_LOW = 6;
    localparam int S_DM_LOW = 7;

    // ---------------------------------------------------------------
    // Link states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_WAIT_IDLE,
        ST_IDLE,
        ST_PACKET,
        ST_EOP_SE0,
        ST_EOP_J
    } link_state_e;
endpackage

// ### verilog/rx_sense_if.sv
// Carrier for synchronised receiver comparator bits.
// Assumes both ends share CLK.
`timescale 1ns/100ps
interface rx_sense_if;
    import line_state_pkg::*;
    sense_t sense;
    modport producer (output sense);
    modport consumer (input sense);
endinterface

// ### verilog/rx_sense_sync.sv
// Two-stage synchroniser for the receiver comparator bits.
// Assumes raw comparator outputs are asynchronous to CLK.
`timescale 1ns/100ps
module rx_sense_sync (
    input wire logic clk,
    input wire logic srst,
    input wire line_state_pkg::sense_t raw,
    rx_sense_if.producer out
);
    import line_state_pkg::*;

    typedef struct packed {
        sense_t meta;
        sense_t sync;
    } sync_s;

    sync_s s_reg;
    sync_s s_next;

    // ---------------------------------------------------------------
    // Two flip-flops per bit
    // ---------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.meta = raw;
        s_next.sync = s_reg.meta;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= '{meta: SENSE_RST, sync: SENSE_RST};
        end else begin
            s_reg <= s_next;
        end
    end

    assign out.sense = s_reg.sync;
endmodule

// ### verilog/usb_fs_line_state_detector.sv
// Full-speed line-state decoder with packet framing and bus reset detect.
// Outputs are registered; SOP, EOP and BUS_RESET are one-cycle pulses.
// Assumes receiver comparator outputs arrive asynchronously on pins.
`timescale 1ns/100ps
module usb_fs_line_state_detector (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic DIFF_POS,
    input wire logic DIFF_NEG,
    input wire logic DP_DRIVEN_HIGH,
    input wire logic DM_DRIVEN_HIGH,
    input wire logic DP_FLOATING_HIGH,
    input wire logic DM_FLOATING_HIGH,
    input wire logic DP_BELOW_LOW,
    input wire logic DM_BELOW_LOW,
    output logic LINE_J,
    output logic LINE_K,
    output logic LINE_SE0,
    output logic FS_IDLE,
    output logic LS_IDLE,
    output logic IN_PACKET,
    output logic SOP,
    output logic EOP,
    output logic BUS_RESET,
    output logic RESET_HELD
);
    import line_state_pkg::*;

    // ---------------------------------------------------------------
    // State record
    // ---------------------------------------------------------------
    typedef struct packed {
        link_state_e state;
        count_t cnt;
        count_t low_cnt;
        logic line_j;
        logic line_k;
        logic line_se0;
        logic fs_idle;
        logic ls_idle;
        logic in_packet;
        logic sop;
        logic eop;
        logic bus_reset;
        logic reset_held;
    } det_s;

    det_s s_reg;
    det_s s_next;
    sense_t raw;
    logic diff_one;
    logic diff_zero;
    logic se0;
    logic fs_idle_now;
    logic ls_idle_now;
    logic lines_low;

    rx_sense_if sense_bus ();

    // ---------------------------------------------------------------
    // Pin capture and synchroniser
    // ---------------------------------------------------------------
    always_comb begin
        raw = SENSE_RST;
        raw[S_DIFF_POS] = DIFF_POS;
        raw[S_DIFF_NEG] = DIFF_NEG;
        raw[S_DP_DRIVEN] = DP_DRIVEN_HIGH;
        raw[S_DM_DRIVEN] = DM_DRIVEN_HIGH;
        raw[S_DP_FLOAT] = DP_FLOATING_HIGH;
        raw[S_DM_FLOAT] = DM_FLOATING_HIGH;
        raw[S_DP_LOW] = DP_BELOW_LOW;
        raw[S_DM_LOW] = DM_BELOW_LOW;
    end

    rx_sense_sync u_sync (
        .clk(CLK),
        .srst(SRST),
        .raw(raw),
        .out(sense_bus.producer)
    );

    // ---------------------------------------------------------------
    // Counter and state helpers
    // ---------------------------------------------------------------
    function automatic count_t sat_inc(input count_t c);
        sat_inc = (c == '1) ? c : c + CNT_ONE;
    endfunction

    function automatic logic reached(input count_t c, input count_t lim);
        reached = sat_inc(c) >= lim;
    endfunction

    function automatic logic in_frame(input link_state_e st);
        in_frame = (st == ST_PACKET) || (st == ST_EOP_SE0) || (st == ST_EOP_J);
    endfunction

    // ---------------------------------------------------------------
    // Line decode
    // ---------------------------------------------------------------
    always_comb begin
        diff_one = sense_bus.sense[S_DIFF_POS] & sense_bus.sense[S_DP_DRIVEN];
        diff_zero = sense_bus.sense[S_DIFF_NEG] & sense_bus.sense[S_DM_DRIVEN];
        se0 = ~sense_bus.sense[S_DP_DRIVEN] & ~sense_bus.sense[S_DM_DRIVEN];
        fs_idle_now = sense_bus.sense[S_DP_FLOAT] & ~sense_bus.sense[S_DM_DRIVEN];
        ls_idle_now = sense_bus.sense[S_DM_FLOAT] & ~sense_bus.sense[S_DP_DRIVEN];
        lines_low = sense_bus.sense[S_DP_LOW] & sense_bus.sense[S_DM_LOW];
    end

    // ---------------------------------------------------------------
    // Framing and reset detection
    // ---------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.line_j = diff_one;
        s_next.line_k = diff_zero;
        s_next.line_se0 = se0;
        s_next.fs_idle = fs_idle_now;
        s_next.ls_idle = ls_idle_now;
        s_next.sop = 1'b0;
        s_next.eop = 1'b0;
        s_next.bus_reset = 1'b0;
        case (s_reg.state)
            ST_WAIT_IDLE: begin
                if (fs_idle_now) begin
                    s_next.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (diff_zero) begin
                    s_next.state = ST_PACKET;
                    s_next.sop = 1'b1;
                end else if (!fs_idle_now && !diff_one) begin
                    s_next.state = ST_WAIT_IDLE;
                end
            end
            ST_PACKET: begin
                if (se0) begin
                    s_next.state = ST_EOP_SE0;
                    s_next.cnt = CNT_ONE;
                end
            end
            ST_EOP_SE0: begin
                if (se0) begin
                    s_next.cnt = sat_inc(s_reg.cnt);
                end else if (s_reg.cnt < EOP_MIN) begin
                    s_next.state = ST_PACKET;
                end else if (diff_one) begin
                    s_next.state = ST_EOP_J;
                    s_next.cnt = CNT_ONE;
                end else begin
                    s_next.state = ST_WAIT_IDLE;
                end
            end
            ST_EOP_J: begin
                if (!diff_one) begin
                    s_next.state = ST_WAIT_IDLE;
                end else if (reached(s_reg.cnt, EOP_MIN)) begin
                    s_next.state = ST_IDLE;
                    s_next.eop = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt + CNT_ONE;
                end
            end
            default: begin
                s_next.state = ST_WAIT_IDLE;
            end
        endcase
        if (lines_low) begin
            s_next.low_cnt = sat_inc(s_reg.low_cnt);
        end else begin
            s_next.low_cnt = CNT_ZERO;
        end
        s_next.reset_held = lines_low && reached(s_reg.low_cnt, RESET_MIN);
        if (s_next.reset_held) begin
            s_next.bus_reset = ~s_reg.reset_held;
            s_next.state = ST_WAIT_IDLE;
            s_next.cnt = CNT_ZERO;
            s_next.sop = 1'b0;
            s_next.eop = 1'b0;
        end
        s_next.in_packet = in_frame(s_next.state);
    end

    // ---------------------------------------------------------------
    // Register update
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_reg <= '{
                state: ST_WAIT_IDLE,
                cnt: CNT_ZERO,
                low_cnt: CNT_ZERO,
                line_j: 1'b0,
                line_k: 1'b0,
                line_se0: 1'b0,
                fs_idle: 1'b0,
                ls_idle: 1'b0,
                in_packet: 1'b0,
                sop: 1'b0,
                eop: 1'b0,
                bus_reset: 1'b0,
                reset_held: 1'b0
            };
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign LINE_J = s_reg.line_j;
    assign LINE_K = s_reg.line_k;
    assign LINE_SE0 = s_reg.line_se0;
    assign FS_IDLE = s_reg.fs_idle;
    assign LS_IDLE = s_reg.ls_idle;
    assign IN_PACKET = s_reg.in_packet;
    assign SOP = s_reg.sop;
    assign EOP = s_reg.eop;
    assign BUS_RESET = s_reg.bus_reset;
    assign RESET_HELD = s_reg.reset_held;
endmodule

// ### verification/host_line_model.sv
// Far-side line model: maps a line code to receiver comparator bits.
// Assumes the bench changes the code just after a rising CLK edge.
`timescale 1ns/100ps
module host_line_model (
    input wire logic [2:0] code,
    output logic [7:0] bits
);
    // ----
    // Bits: diff+, diff-, drv+, drv-, flt+, flt-, low+, low-
    // ----
    always_comb begin
        case (code)
            3'h1: bits = 8'h85;
            3'h2: bits = 8'h4a;
            3'h3: bits = 8'h00;
            3'h4: bits = 8'hc0;
            3'h5: bits = 8'h6a;
            default: bits = 8'h95;
        endcase
    end
endmodule

// ### verification/line_state_asserts.sv
// Property checker for the line-state detector.
// Assumes it is bound into the top module and sees its ports by name.
`timescale 1ns/100ps
module line_state_asserts (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic DIFF_POS,
    input wire logic DIFF_NEG,
    input wire logic DP_DRIVEN_HIGH,
    input wire logic DM_DRIVEN_HIGH,
    input wire logic DP_FLOATING_HIGH,
    input wire logic DM_FLOATING_HIGH,
    input wire logic DP_BELOW_LOW,
    input wire logic DM_BELOW_LOW,
    input wire logic LINE_J,
    input wire logic LINE_K,
    input wire logic LINE_SE0,
    input wire logic FS_IDLE,
    input wire logic LS_IDLE,
    input wire logic IN_PACKET,
    input wire logic SOP,
    input wire logic EOP,
    input wire logic BUS_RESET,
    input wire logic RESET_HELD
);
    logic [2:0] up_reg;
    logic [8:0] low_reg;
    wire ok = up_reg == 3'h4;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            up_reg <= 3'h0;
            low_reg <= 9'h000;
        end else begin
            if (!ok) begin
                up_reg <= up_reg + 3'h1;
            end
            if (!(DP_BELOW_LOW && DM_BELOW_LOW)) begin
                low_reg <= 9'h000;
            end else if (low_reg != 9'h1ff) begin
                low_reg <= low_reg + 9'h001;
            end
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    AST_J: assert property (ok |-> LINE_J ==
        ($past(DIFF_POS, 3) && $past(DP_DRIVEN_HIGH, 3))) else $error("J decode wrong");
    AST_K: assert property (ok |-> LINE_K ==
        ($past(DIFF_NEG, 3) && $past(DM_DRIVEN_HIGH, 3))) else $error("K decode wrong");
    AST_SE0: assert property (ok |-> LINE_SE0 ==
        (!$past(DP_DRIVEN_HIGH, 3) && !$past(DM_DRIVEN_HIGH, 3))) else $error("SE0 wrong");
    AST_FS: assert property (ok |-> FS_IDLE ==
        ($past(DP_FLOATING_HIGH, 3) && !$past(DM_DRIVEN_HIGH, 3))) else $error("FS idle wrong");
    AST_LS: assert property (ok |-> LS_IDLE ==
        ($past(DM_FLOATING_HIGH, 3) && !$past(DP_DRIVEN_HIGH, 3))) else $error("LS idle wrong");
    AST_SOP: assert property (SOP |-> LINE_K && IN_PACKET && !$past(LINE_K))
        else $error("SOP without idle to K");
    AST_PKT: assert property ($rose(IN_PACKET) |-> SOP ##1 !SOP)
        else $error("packet start without SOP pulse");
    AST_EOP: assert property (EOP |-> !IN_PACKET && $past(LINE_J, 6)
        && $past(LINE_SE0, 7) && $past(LINE_SE0, 13)) else $error("EOP sequence wrong");
    AST_RST: assert property (BUS_RESET |-> low_reg >= 9'h0fb && low_reg <= 9'h0fe
        && RESET_HELD ##1 !IN_PACKET && !BUS_RESET) else $error("bus reset timing wrong");
    AST_HELD: assert property (RESET_HELD |=> RESET_HELD ==
        ($past(DP_BELOW_LOW, 3) && $past(DM_BELOW_LOW, 3))) else $error("reset hold wrong");
    cover property (SOP);
    cover property (EOP);
    cover property (BUS_RESET);
endmodule
bind usb_fs_line_state_detector line_state_asserts line_state_asserts_i (.*);

// ### verification/testbench.sv
// Self-checking bench for the line-state detector.
// Assumes the host line model drives the receiver bits.
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] code = 3'h3;
    logic [7:0] b;
    logic j, k, se0, fsi, lsi, inp, sop, eop, brst, held;
    logic [1:0] notes[$];
    logic [1:0] want;
    logic [2:0] tcode [6] = '{3'h2, 3'h5, 3'h3, 3'h4, 3'h1, 3'h0};
    logic [4:0] texp [6] = '{5'h08, 5'h09, 5'h04, 5'h04, 5'h10, 5'h12};
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    host_line_model host_line_model_i (.code(code), .bits(b));
    usb_fs_line_state_detector usb_fs_line_state_detector_i (.CLK(clk), .SRST(srst),
        .DIFF_POS(b[0]), .DIFF_NEG(b[1]), .DP_DRIVEN_HIGH(b[2]), .DM_DRIVEN_HIGH(b[3]),
        .DP_FLOATING_HIGH(b[4]), .DM_FLOATING_HIGH(b[5]), .DP_BELOW_LOW(b[6]),
        .DM_BELOW_LOW(b[7]), .LINE_J(j), .LINE_K(k), .LINE_SE0(se0), .FS_IDLE(fsi),
        .LS_IDLE(lsi), .IN_PACKET(inp), .SOP(sop), .EOP(eop), .BUS_RESET(brst),
        .RESET_HELD(held));
    task check(input string name, input logic [4:0] seen, input logic [4:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task drive(input logic [2:0] c, input int n);
        code <= c;
        repeat (n) @(posedge clk);
    endtask
    task packet(input int nbits);
        int i;
        notes.push_back(2'h1);
        drive(3'h2, 8);
        for (i = 0; i < nbits; i++) begin
            drive(3'($urandom_range(2, 1)), 8);
        end
        drive(3'h3, 8);
        notes.push_back(2'h2);
        drive(3'h1, 8);
    endtask
    // ----
    // Event watcher and run limit
    // ----
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (sop || eop || brst) begin
            want = (notes.size() > 0) ? notes.pop_front() : 2'h0;
            check("event", {3'h0, brst ? 2'h3 : {eop, sop}}, {3'h0, want});
        end
        if (cyc == 5000) begin
            n_mismatch++;
            finish_test;
        end
    end
    initial begin
        void'($urandom(32'h604c376d));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        foreach (tcode[i]) begin
            drive(tcode[i], 5);
            check("lines", {j, k, se0, fsi, lsi}, texp[i]);
        end
        $display("decode test done");
        drive(3'h0, 8);
        repeat (3) packet($urandom_range(20, 4));
        $display("packet test done");
        notes.push_back(2'h1);
        drive(3'h2, 8);
        drive(3'h3, 5);
        drive(3'h2, 8);
        check("in_packet", {4'h0, inp}, 5'h01);
        drive(3'h3, 8);
        drive(3'h2, 8);
        check("in_packet", {4'h0, inp}, 5'h00);
        drive(3'h0, 8);
        notes.push_back(2'h1);
        drive(3'h2, 8);
        drive(3'h3, 8);
        drive(3'h1, 4);
        drive(3'h2, 8);
        check("in_packet", {4'h0, inp}, 5'h00);
        drive(3'h0, 8);
        packet(4);
        $display("abort test done");
        notes.push_back(2'h1);
        drive(3'h2, 8);
        notes.push_back(2'h3);
        drive(3'h4, 1100);
        check("held", {3'h0, held, inp}, 5'h02);
        drive(3'h0, 8);
        check("held", {4'h0, held}, 5'h00);
        packet(2);
        drive(3'h0, 8);
        check("notes", 5'(notes.size()), 5'h00);
        $display("reset test done");
        finish_test;
    end
endmodule
